// File: pkg/hba_defines.svh
/*
 * Offsets, field positions, reset values and codes of the host bus access port.
 * Assumes inclusion by bare name from the design and bench files.
 */
`ifndef HBA_DEFINES_SVH
`define HBA_DEFINES_SVH
`define HBA_REG_LIMIT 24'h00fc00
`define HBA_OFS_CTRL 14'h0000
`define HBA_OFS_FIFO 14'h0001
`define HBA_OFS_STAT 14'h0002
`define HBA_CTRL_DMA_EN 0
`define HBA_CTRL_DSTP_EN 1
`define HBA_CTRL_TO_EN 2
`define HBA_CTRL_SWRST 3
`define HBA_CTRL_TO_LSB 8
`define HBA_CTRL_TO_MSB 15
`define HBA_CTRL_RST 32'h0000ff00
`define HBA_CTRL_MASK 32'h0000ff07
`define HBA_STAT_TO 0
`define HBA_STAT_WIDE 1
`define HBA_STAT_LVL_LSB 8
`define HBA_SZ_BYTE 2'h0
`define HBA_SZ_HALF 2'h1
`define HBA_SZ_WORD 2'h2
`endif

// File: pkg/hba_pkg.sv
/*
 * Types shared by the host bus access port.
 * Assumes the defines header is compiled alongside.
 */
package hba_pkg;
    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_mem = 3'b010,
        st_push = 3'b100
    } hba_state_t;
endpackage

// File: src/hba_port.sv
/*
 * Host bus access port: register space, memory-mapped SDRAM space, command input
 * FIFO with head readback, DMA flags and ready timeout, plus its FIFO.
 * Assumes one clock; the SDRAM side acknowledges each request with mem_ack and the
 * pixel processor drains the FIFO with pix_ready.
 */
// How it works
// - SDRAM writes of word, halfword and byte size go out with matching byte enables.
// - Register reads return correct data for any access size.
// - SDRAM reads fetch a word and return the addressed lane for every size.
// - Addresses below the register limit go to registers, the rest to SDRAM.
// - The width pin low selects 16-bit mode, high selects 32-bit mode.
// - Reading the FIFO address returns the head word without popping it.
// - The pixel processor pops on ref_clk independently of host reads, so host reads may skip words.
// - An enabled ready timeout releases a stuck access and flags it.
// - With the stop enable clear no pulse appears on the DMA stop output.
// - In 16-bit mode a word travels as two halfwords, most significant first.
`timescale 1ns/100ps
`include "hba_defines.svh"

module hba_fifo #(
    parameter int W = 32,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(DEPTH+2)-1:0] level
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+2);
    // Pointers wrap naturally, so DEPTH must be a power of two.
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] wptr;
        logic [PW-1:0] rptr;
        logic [CW-1:0] cnt;
        logic ov;
        logic [W-1:0] od;
    } hba_fifo_t;
    hba_fifo_t q, d;
    logic load;
    logic pop;
    logic push;
    logic stored;
    logic taken;

    assign in_ready = q.cnt < CW'(DEPTH);
    assign out_valid = q.ov;
    assign out_data = q.od;
    assign level = q.cnt + CW'(q.ov);

    always_comb begin
        d = q;
        pop = q.ov && out_ready;
        push = in_valid && in_ready;
        load = !q.ov || pop;
        stored = 1'b0;
        taken = 1'b0;
        if (pop) begin
            d.ov = 1'b0;
        end
        if (load && q.cnt != '0) begin
            d.od = q.mem[q.rptr];
            d.ov = 1'b1;
            d.rptr = PW'(q.rptr + 1'b1);
            taken = 1'b1;
        end
        if (push) begin
            if (load && q.cnt == '0) begin
                d.od = in_data;
                d.ov = 1'b1;
            end else begin
                d.mem[q.wptr] = in_data;
                d.wptr = PW'(q.wptr + 1'b1);
                stored = 1'b1;
            end
        end
        d.cnt = CW'(q.cnt + CW'(stored) - CW'(taken));
        if (flush) begin
            d.wptr = '0;
            d.rptr = '0;
            d.cnt = '0;
            d.ov = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

module hba_port #(
    parameter int AW = 24,
    parameter int DEPTH = 32
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic width_sel,
    input wire logic [AW-1:0] host_addr,
    input wire logic [31:0] host_wdata,
    input wire logic [1:0] host_size,
    input wire logic host_we,
    input wire logic host_re,
    output logic [31:0] host_rdata,
    output logic host_ready_n,
    output logic mem_req,
    output logic mem_we,
    output logic [AW-1:0] mem_addr,
    output logic [31:0] mem_wdata,
    output logic [3:0] mem_be,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_ack,
    output logic pix_valid,
    input wire logic pix_ready,
    output logic [31:0] pix_data,
    output logic dma_request,
    output logic dma_stop_out
);
    import hba_pkg::*;
    localparam int CW = $clog2(DEPTH+2);

    function automatic logic [31:0] hba_lane(input logic [31:0] w, input logic [1:0] ofs,
                                             input logic [1:0] sz);
        logic [31:0] r;
        r = w;
        if (sz == `HBA_SZ_BYTE) begin
            r = w >> {~ofs, 3'h0};
            r = {24'h000000, r[7:0]};
        end else if (sz == `HBA_SZ_HALF) begin
            r = w >> {~ofs[1], 4'h0};
            r = {16'h0000, r[15:0]};
        end
        return r;
    endfunction

    function automatic logic [3:0] hba_be(input logic [1:0] ofs, input logic [1:0] sz);
        logic [3:0] b;
        b = 4'hf;
        if (sz == `HBA_SZ_BYTE) begin
            b = 4'h8 >> ofs;
        end else if (sz == `HBA_SZ_HALF) begin
            b = ofs[1] ? 4'h3 : 4'hc;
        end
        return b;
    endfunction

    typedef struct packed {
        logic [2:0] sync;
        logic wide;
        hba_state_t st;
        logic ready_n;
        logic [31:0] rdata;
        logic [31:0] ctrl;
        logic to_flag;
        logic [15:0] hi_w;
        logic [31:0] lo_r;
        logic [7:0] to_cnt;
        logic mreq;
        logic mwe;
        logic [AW-1:0] maddr;
        logic [31:0] mwd;
        logic [3:0] mbe;
        logic [1:0] rofs;
        logic [1:0] rsz;
        logic push;
        logic [31:0] pdata;
        logic dstp;
        logic flush;
        logic dreq;
    } hba_state_reg_t;
    hba_state_reg_t s_q, s_d;

    logic fifo_in_ready;
    logic fifo_ov;
    logic [31:0] fifo_od;
    logic [CW-1:0] fifo_lvl;
    logic is_reg;
    logic [13:0] widx;
    logic [1:0] ofs;
    logic [31:0] rword;
    logic [31:0] wput;
    logic [31:0] wval;
    logic wcommit;
    logic [3:0] be;

    hba_fifo #(.W(32), .DEPTH(DEPTH)) u_fifo (
        .clk(ref_clk),
        .rst(rst),
        .flush(s_q.flush),
        .in_valid(s_q.push),
        .in_ready(fifo_in_ready),
        .in_data(s_q.pdata),
        .out_valid(fifo_ov),
        .out_ready(pix_ready),
        .out_data(fifo_od),
        .level(fifo_lvl)
    );

    assign is_reg = host_addr < AW'(`HBA_REG_LIMIT);
    assign widx = host_addr[15:2];
    assign ofs = host_addr[1:0];
    assign be = hba_be(ofs, host_size);
    assign host_rdata = s_q.rdata;
    assign host_ready_n = s_q.ready_n;
    assign mem_req = s_q.mreq;
    assign mem_we = s_q.mwe;
    assign mem_addr = s_q.maddr;
    assign mem_wdata = s_q.mwd;
    assign mem_be = s_q.mbe;
    assign pix_valid = fifo_ov;
    assign pix_data = fifo_od;
    assign dma_request = s_q.dreq;
    assign dma_stop_out = s_q.dstp;

    always_comb begin
        s_d = s_q;
        rword = 32'h00000000;
        wput = host_wdata;
        wval = host_wdata;
        wcommit = 1'b0;
        s_d.dstp = 1'b0;
        s_d.flush = 1'b0;
        // Only the agreeing second and third stages may change the mode.
        s_d.sync = {s_q.sync[1:0], width_sel};
        if (s_q.sync[1] == s_q.sync[2]) begin
            s_d.wide = s_q.sync[2];
        end
        case (widx)
            `HBA_OFS_CTRL: rword = s_q.ctrl;
            `HBA_OFS_FIFO: rword = fifo_ov ? fifo_od : 32'h00000000;
            `HBA_OFS_STAT: begin
                rword[`HBA_STAT_TO] = s_q.to_flag;
                rword[`HBA_STAT_WIDE] = s_q.wide;
                rword[`HBA_STAT_LVL_LSB +: CW] = fifo_lvl;
            end
            default: rword = 32'h00000000;
        endcase
        if (host_size == `HBA_SZ_BYTE) begin
            wput = {4{host_wdata[7:0]}};
        end else if (host_size == `HBA_SZ_HALF) begin
            wput = {2{host_wdata[15:0]}};
        end
        if (s_q.wide) begin
            for (int i = 0; i < 4; i++) begin
                wval[i*8 +: 8] = be[i] ? wput[i*8 +: 8] : rword[i*8 +: 8];
            end
            wcommit = 1'b1;
        end else if (ofs[1]) begin
            wval = {s_q.hi_w, host_wdata[15:0]};
            wcommit = 1'b1;
        end
        case (s_q.st)
            st_idle: begin
                s_d.to_cnt = 8'h00;
                if (host_re && is_reg) begin
                    if (s_q.wide || !ofs[1]) begin
                        s_d.lo_r = rword;
                        s_d.rdata = hba_lane(rword, ofs, host_size);
                    end else begin
                        s_d.rdata = hba_lane(s_q.lo_r, ofs, host_size);
                    end
                end else if (host_we && is_reg) begin
                    if (!s_q.wide && !ofs[1]) begin
                        s_d.hi_w = host_wdata[15:0];
                    end
                    if (wcommit && widx == `HBA_OFS_CTRL) begin
                        s_d.ctrl = wval & `HBA_CTRL_MASK;
                        // Software must stop its own DMA first; the pulse is not reliable.
                        if (s_q.ctrl[`HBA_CTRL_DSTP_EN] && (wval[`HBA_CTRL_SWRST] ||
                            (s_q.ctrl[`HBA_CTRL_DMA_EN] && !wval[`HBA_CTRL_DMA_EN]))) begin
                            s_d.dstp = 1'b1;
                        end
                        s_d.flush = wval[`HBA_CTRL_SWRST];
                    end else if (wcommit && widx == `HBA_OFS_STAT) begin
                        if (wval[`HBA_STAT_TO]) begin
                            s_d.to_flag = 1'b0;
                        end
                    end else if (wcommit && widx == `HBA_OFS_FIFO) begin
                        s_d.push = 1'b1;
                        s_d.pdata = wval;
                        s_d.ready_n = 1'b0;
                        s_d.st = st_push;
                    end
                end else if ((host_re || host_we) && !is_reg) begin
                    s_d.mreq = 1'b1;
                    s_d.mwe = host_we;
                    s_d.maddr = host_addr;
                    s_d.mwd = wput;
                    s_d.mbe = be;
                    s_d.rofs = ofs;
                    s_d.rsz = host_size;
                    s_d.ready_n = 1'b0;
                    s_d.st = st_mem;
                end
            end
            st_mem: begin
                s_d.to_cnt = 8'(s_q.to_cnt + 1'b1);
                if (mem_ack) begin
                    s_d.mreq = 1'b0;
                    if (!s_q.mwe) begin
                        s_d.rdata = hba_lane(mem_rdata, s_q.rofs, s_q.rsz);
                    end
                    s_d.ready_n = 1'b1;
                    s_d.st = st_idle;
                end
            end
            st_push: begin
                s_d.to_cnt = 8'(s_q.to_cnt + 1'b1);
                if (fifo_in_ready) begin
                    s_d.push = 1'b0;
                    s_d.ready_n = 1'b1;
                    s_d.st = st_idle;
                end
            end
            default: begin
                s_d.st = st_idle;
                s_d.ready_n = 1'b1;
            end
        endcase
        if (s_q.st != st_idle && s_d.st != st_idle && s_q.ctrl[`HBA_CTRL_TO_EN] &&
            s_q.to_cnt >= s_q.ctrl[`HBA_CTRL_TO_MSB:`HBA_CTRL_TO_LSB]) begin
            s_d.mreq = 1'b0;
            s_d.push = 1'b0;
            s_d.rdata = 32'h00000000;
            s_d.ready_n = 1'b1;
            s_d.to_flag = 1'b1;
            s_d.st = st_idle;
        end
        s_d.dreq = s_d.ctrl[`HBA_CTRL_DMA_EN] && fifo_in_ready;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.st <= st_idle;
            s_q.ready_n <= 1'b1;
            s_q.ctrl <= `HBA_CTRL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_mem_lane: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.st == st_mem && mem_ack && !s_q.mwe |=> host_ready_n &&
        host_rdata == hba_lane($past(mem_rdata), $past(s_q.rofs), $past(s_q.rsz)))
        else $error("SDRAM read lane wrong");
    chk_reg_read_now: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.st == st_idle && host_re && is_reg |=> host_ready_n && s_q.st == st_idle)
        else $error("register read waited");
    chk_no_stop_pulse: assert property (@(posedge ref_clk) disable iff (rst)
        !s_q.ctrl[`HBA_CTRL_DSTP_EN] |=> !dma_stop_out)
        else $error("stop pulse while disabled");
    chk_fifo_head_peek: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.st == st_idle && host_re && is_reg && widx == `HBA_OFS_FIFO && s_q.wide &&
        host_size == `HBA_SZ_WORD && fifo_ov |=> host_rdata == $past(fifo_od))
        else $error("FIFO head readback wrong");
    chk_timeout_bound: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.ctrl[`HBA_CTRL_TO_EN] && $stable(s_q.ctrl) && s_q.st != st_idle |->
        s_q.to_cnt <= s_q.ctrl[`HBA_CTRL_TO_MSB:`HBA_CTRL_TO_LSB])
        else $error("timeout overrun");
    chk_region_split: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.st == st_idle && (host_we || host_re) && !is_reg |=>
        mem_req && host_ready_n == 1'b0 && mem_addr == $past(host_addr))
        else $error("SDRAM access not issued");
    chk_byte_enable: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.st == st_idle && host_we && !is_reg && host_size == `HBA_SZ_BYTE |=>
        $onehot(mem_be) && mem_we)
        else $error("byte write enables wrong");
    chk_mode_filter: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.sync[1] != s_q.sync[2] |=> s_q.wide == $past(s_q.wide))
        else $error("mode changed on disagreement");
    chk_half_order: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.st == st_idle && host_we && is_reg && widx == `HBA_OFS_FIFO && !s_q.wide &&
        ofs[1] |=> s_q.pdata == {$past(s_q.hi_w), $past(host_wdata[15:0])})
        else $error("halfword order wrong");
    chk_ready_held: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.st != st_idle |-> !host_ready_n)
        else $error("ready released early");
    cov_mem_read: cover property (@(posedge ref_clk) disable iff (rst)
        s_q.st == st_mem && mem_ack && !s_q.mwe);
    cov_timeout: cover property (@(posedge ref_clk) disable iff (rst) $rose(s_q.to_flag));
    cov_fifo_stall: cover property (@(posedge ref_clk) disable iff (rst)
        s_q.st == st_push && !fifo_in_ready);
    cov_peek_pop: cover property (@(posedge ref_clk) disable iff (rst)
        host_re && widx == `HBA_OFS_FIFO && pix_ready && fifo_ov);
endmodule

// File: verification/hba_mem_model.sv
/*
 * SDRAM side model for the host bus access port: a small word memory with byte enables.
 * Assumes one clock; the bench sets the answer latency and can make the model hang.
 */
`timescale 1ns/100ps
module hba_mem_model #(
    parameter int AW = 24
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] lat,
    input wire logic hang,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [AW-1:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic [3:0] mem_be,
    output logic [31:0] mem_rdata,
    output logic mem_ack
);
    logic [31:0] mem [0:63];
    logic [7:0] cnt;
    logic [5:0] idx;
    assign idx = mem_addr[7:2];
    // Outside an ack the data bus toggles, so stale data never passes for an answer.
    always @(posedge ref_clk) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (rst) begin
            cnt <= 8'h00;
            mem_rdata <= 32'h00000000;
        end else if (mem_req && !mem_ack && !hang) begin
            if (cnt >= lat) begin
                cnt <= 8'h00;
                mem_ack <= 1'b1;
                mem_rdata <= mem[idx];
                for (int b = 0; b < 4; b++) begin
                    if (mem_we && mem_be[b]) begin
                        mem[idx][8*b +: 8] <= mem_wdata[8*b +: 8];
                    end
                end
            end else begin
                cnt <= cnt + 8'h01;
            end
        end
    end
endmodule

// File: verification/testbench.sv
/*
 * Self-checking bench of the host bus access port with an SDRAM side model.
 * Assumes the defines header and package are compiled first.
 */
`timescale 1ns/100ps
`include "hba_defines.svh"
module testbench;
    import hba_pkg::*;
    // ----------------------------------------
    // Bench signals
    // ----------------------------------------
    localparam int DEPTH = 32;
    localparam logic [1:0] sz_b = `HBA_SZ_BYTE;
    localparam logic [1:0] sz_h = `HBA_SZ_HALF;
    localparam logic [1:0] sz_w = `HBA_SZ_WORD;
    localparam logic [23:0] a_ctrl = 24'h000000;
    localparam logic [23:0] a_fifo = 24'h000004;
    localparam logic [23:0] a_stat = 24'h000008;
    logic ref_clk = 1'b0, rst = 1'b1, width_sel = 1'b1, host_we = 1'b0, host_re = 1'b0;
    logic pix_ready = 1'b0, hang = 1'b0, saw_low;
    logic [23:0] host_addr = 24'h000000;
    logic [31:0] host_wdata = 32'h00000000, host_dma_control = 32'hc0000000;
    logic [1:0] host_size = 2'h0;
    logic [7:0] lat = 8'h00;
    logic [31:0] host_rdata, mem_wdata, mem_rdata, pix_data, rd;
    logic [23:0] mem_addr;
    logic [3:0] mem_be;
    logic host_ready_n, mem_req, mem_we, mem_ack, pix_valid, dma_request, dma_stop_out;
    int err_count = 0, comparisons = 0, waited = 0, stops = 0;
    always #10 ref_clk = ~ref_clk;
    // The stop output is only counted, never used to steer the host side.
    always @(posedge ref_clk) begin
        if (dma_stop_out === 1'b1) stops++;
    end
    hba_port #(.AW(24), .DEPTH(DEPTH)) i_hba_port (.ref_clk(ref_clk), .rst(rst),
        .width_sel(width_sel), .host_addr(host_addr), .host_wdata(host_wdata),
        .host_size(host_size), .host_we(host_we), .host_re(host_re), .host_rdata(host_rdata),
        .host_ready_n(host_ready_n), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
        .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_data(pix_data),
        .dma_request(dma_request), .dma_stop_out(dma_stop_out));
    hba_mem_model #(.AW(24)) i_hba_mem_model (.ref_clk(ref_clk), .rst(rst), .lat(lat),
        .hang(hang), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // One strobe cycle, then a bounded wait for ready; the result lands in rd.
    task automatic acc(input logic we, input logic [23:0] a, input logic [31:0] d,
                       input logic [1:0] s);
        int n;
        @(posedge ref_clk);
        host_we <= we;
        host_re <= !we;
        host_addr <= a;
        host_wdata <= d;
        host_size <= s;
        @(posedge ref_clk);
        host_we <= 1'b0;
        host_re <= 1'b0;
        #1;
        saw_low = (host_ready_n === 1'b0);
        n = 0;
        while (host_ready_n !== 1'b1 && n < 200) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        waited = n;
        rd = host_rdata;
        if (n >= 200) begin
            err_count++;
            stop_test;
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        chk(host_ready_n, 1'b1);
        acc(1'b0, a_ctrl, 0, sz_w);
        chk(rd, `HBA_CTRL_RST);
        acc(1'b0, 24'h000002, 0, sz_h);
        chk(rd, 32'h0000ff00);
        acc(1'b0, 24'h000002, 0, sz_b);
        chk(rd, 32'h000000ff);
        acc(1'b0, a_stat, 0, sz_w);
        chk(rd[`HBA_STAT_WIDE], 1'b1);
        acc(1'b1, 24'h000010, 32'h0000005a, sz_w);
        acc(1'b0, 24'h000010, 0, sz_w);
        chk(rd, 32'h00000000);
        $display("test reset_regs done");
    endtask
    task automatic t_sdram(input logic [7:0] l);
        lat <= l;
        acc(1'b1, 24'h010004, 32'h11223344, sz_w);
        chk(saw_low, 1'b1);
        acc(1'b1, 24'h010005, 32'h000000aa, sz_b);
        acc(1'b1, 24'h010006, 32'h0000beef, sz_h);
        acc(1'b0, 24'h010004, 0, sz_w);
        chk(rd, 32'h11aabeef);
        chk(saw_low, 1'b1);
        acc(1'b0, 24'h010004, 0, sz_h);
        chk(rd, 32'h000011aa);
        acc(1'b0, 24'h010007, 0, sz_b);
        chk(rd, 32'h000000ef);
        $display("test sdram latency %0d done", l);
    endtask
    task automatic t_fifo;
        int n;
        int k;
        acc(1'b1, a_ctrl, 32'h0000ff01, sz_w);
        for (int i = 0; i <= DEPTH; i++) acc(1'b1, a_fifo, 32'h00000100 + i, sz_w);
        idle(2);
        chk(dma_request, 1'b0);
        acc(1'b0, a_fifo, 0, sz_w);
        chk(rd, 32'h00000100);
        acc(1'b0, a_fifo, 0, sz_w);
        chk(rd, 32'h00000100);
        acc(1'b0, a_stat, 0, sz_w);
        chk(rd[15:8], DEPTH + 1);
        n = 0;
        k = 0;
        // The drain stalls on a fixed pattern so that pops are not back to back only.
        while (k <= DEPTH && n < 400) begin
            @(posedge ref_clk);
            pix_ready <= (n % 4) != 1;
            #1;
            if (pix_valid === 1'b1 && pix_ready === 1'b1) begin
                chk(pix_data, 32'h00000100 + k);
                k++;
            end
            n++;
        end
        @(posedge ref_clk);
        pix_ready <= 1'b0;
        if (n >= 400) begin
            err_count++;
            stop_test;
        end
        idle(2);
        chk(pix_valid, 1'b0);
        chk(dma_request, 1'b1);
        acc(1'b0, a_fifo, 0, sz_w);
        chk(rd, 32'h00000000);
        $display("test fifo done");
    endtask
    task automatic t_dma;
        int s;
        acc(1'b1, a_ctrl, 32'h0000ff03, sz_w);
        s = stops;
        acc(1'b1, a_ctrl, 32'h0000ff02, sz_w);
        idle(3);
        chk(stops - s, 1);
        acc(1'b1, a_ctrl, 32'h0000ff01, sz_w);
        s = stops;
        acc(1'b1, a_ctrl, 32'h0000ff00, sz_w);
        idle(3);
        chk(stops - s, 0);
        acc(1'b1, a_ctrl, 32'h0000ff03, sz_w);
        acc(1'b1, a_fifo, 32'hdead0001, sz_w);
        host_dma_control[30] = 1'b0;
        host_dma_control[31] = 1'b0;
        s = stops;
        acc(1'b1, a_ctrl, 32'h0000ff0b, sz_w);
        idle(3);
        chk(stops - s, 1);
        chk(pix_valid, 1'b0);
        acc(1'b0, a_ctrl, 0, sz_w);
        chk(rd, 32'h0000ff03);
        acc(1'b1, a_ctrl, 32'h0000ff00, sz_w);
        $display("test dma_stop done");
    endtask
    task automatic t_timeout;
        acc(1'b1, a_ctrl, 32'h00000a04, sz_w);
        hang <= 1'b1;
        acc(1'b0, 24'h010004, 0, sz_w);
        chk(rd, 32'h00000000);
        chk(waited >= 9 && waited <= 13, 1'b1);
        acc(1'b0, a_stat, 0, sz_w);
        chk(rd[`HBA_STAT_TO], 1'b1);
        acc(1'b1, a_stat, 32'h00000001, sz_w);
        acc(1'b0, a_stat, 0, sz_w);
        chk(rd[`HBA_STAT_TO], 1'b0);
        hang <= 1'b0;
        acc(1'b1, a_ctrl, 32'h0000ff00, sz_w);
        $display("test timeout done");
    endtask
    // The input queue address is never read here while the port is narrow.
    task automatic t_narrow;
        width_sel <= 1'b0;
        idle(6);
        acc(1'b1, a_fifo, 32'h0000abcd, sz_h);
        acc(1'b1, 24'h000006, 32'h00001234, sz_h);
        acc(1'b1, a_ctrl, 32'h00000000, sz_h);
        acc(1'b1, 24'h000002, 32'h00001205, sz_h);
        acc(1'b0, a_ctrl, 0, sz_h);
        chk(rd, 32'h00000000);
        acc(1'b0, 24'h000002, 0, sz_h);
        chk(rd, 32'h00001205);
        acc(1'b0, 24'h000001, 0, sz_b);
        acc(1'b0, 24'h000003, 0, sz_b);
        chk(rd, 32'h00000005);
        acc(1'b0, a_stat, 0, sz_h);
        acc(1'b0, 24'h00000a, 0, sz_h);
        chk(rd[`HBA_STAT_WIDE], 1'b0);
        width_sel <= 1'b1;
        idle(6);
        acc(1'b0, a_stat, 0, sz_w);
        chk(rd[`HBA_STAT_WIDE], 1'b1);
        acc(1'b0, a_ctrl, 0, sz_w);
        chk(rd, 32'h00001205);
        acc(1'b0, a_fifo, 0, sz_w);
        chk(rd, 32'habcd1234);
        $display("test narrow_mode done");
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        idle(5);
        t_reset;
        t_sdram(8'h00);
        t_sdram(8'h03);
        t_fifo;
        t_dma;
        t_timeout;
        t_narrow;
        stop_test;
    end
endmodule
